// [core/iso_ring_pkg.sv]
package iso_ring_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int SIZE_W = 9;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 7;
	localparam int REG_AW = 4;

	// ----------------------------------------------------------------
	// Register offsets (word index on the register port)
	// ----------------------------------------------------------------
	localparam logic [REG_AW-1:0] CTRL_OFS       = 4'h0;
	localparam logic [REG_AW-1:0] BUF_BASE_OFS   = 4'h1;
	localparam logic [REG_AW-1:0] BUF_SIZE_OFS   = 4'h2;
	localparam logic [REG_AW-1:0] RD_PTR_OFS     = 4'h3;
	localparam logic [REG_AW-1:0] WR_PTR_OFS     = 4'h4;
	localparam logic [REG_AW-1:0] OUT_EVEN_OFS   = 4'h5;
	localparam logic [REG_AW-1:0] OUT_ODD_OFS    = 4'h6;
	localparam logic [REG_AW-1:0] IN_FIRST_OFS   = 4'h7;
	localparam logic [REG_AW-1:0] IN_SECOND_OFS  = 4'h8;
	localparam logic [REG_AW-1:0] LEVEL_OFS      = 4'h9;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_DIR_IN_BIT = 1;
	localparam int CTRL_BPS_LSB    = 2;
	localparam int NR_BIT          = 7;

	localparam logic [ADDR_W-1:0] BASE_RST  = 8'h00;
	localparam logic [SIZE_W-1:0] SIZE_RST  = 9'h100;
	localparam logic [7:0]        INCNT_RST = 8'h80;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int USB_MHZ          = 12;
	localparam int MARK_USB_PERIODS = 1511;
	localparam int FRAME_US         = 1000;
	localparam int MARK_CYCLES      = (MARK_USB_PERIODS * CLK_MHZ + USB_MHZ - 1) / USB_MHZ;
	localparam int FRAME_CYCLES     = FRAME_US * CLK_MHZ;
	localparam int TM_CNT_W         = 18;

	// ----------------------------------------------------------------
	// Ring arithmetic
	// ----------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] ring_next(input logic [ADDR_W-1:0] ptr,
		input logic [ADDR_W-1:0] base, input logic [SIZE_W-1:0] size);
		logic [SIZE_W-1:0] last;
		last = SIZE_W'(base) + size - 9'h001;
		ring_next = (ptr == last[ADDR_W-1:0]) ? base : ADDR_W'(ptr + 8'h01);
	endfunction

	function automatic logic [SIZE_W-1:0] ring_fill(input logic [ADDR_W-1:0] wr,
		input logic [ADDR_W-1:0] rd, input logic [SIZE_W-1:0] size);
		ring_fill = (wr >= rd) ? SIZE_W'(wr - rd) : SIZE_W'(SIZE_W'(wr) + size - SIZE_W'(rd));
	endfunction

endpackage

// [core/ring_cfg_if.sv]
`timescale 1ns/10ps
interface ring_cfg_if;
	logic [iso_ring_pkg::ADDR_W-1:0] base;
	logic [iso_ring_pkg::SIZE_W-1:0] size;
	logic                            init;
	modport cfg  (output base, output size, output init);
	modport ring (input base, input size, input init);
endinterface

// [core/circ_ptr.sv]
`timescale 1ns/10ps
module circ_ptr (
	input  wire logic                            clk_i,
	input  wire logic                            rst_n_i,
	ring_cfg_if.ring                             cfg,
	input  wire logic                            adv_i,
	output logic      [iso_ring_pkg::ADDR_W-1:0] ptr_o
);
	logic [iso_ring_pkg::ADDR_W-1:0] ptr_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ptr_r <= iso_ring_pkg::BASE_RST;
		end else if (cfg.init) begin
			ptr_r <= cfg.base;
		end else if (adv_i) begin
			ptr_r <= iso_ring_pkg::ring_next(ptr_r, cfg.base, cfg.size);
		end
	end

	assign ptr_o = ptr_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	ptr_init_a: assert property (cfg.init |=> ptr_r == $past(cfg.base))
		else $error("pointer did not return to base on init");
	ptr_wrap_a: assert property (adv_i && !cfg.init |=>
		ptr_r == iso_ring_pkg::ring_next($past(ptr_r), cfg.base, cfg.size))
		else $error("pointer advance or wrap wrong");
endmodule // circ_ptr

// [core/time_mark_gen.sv]
`timescale 1ns/10ps
module time_mark_gen #(
	parameter int FRAME_CYCLES = iso_ring_pkg::FRAME_CYCLES,
	parameter int MARK_CYCLES  = iso_ring_pkg::MARK_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic sof_i,
	output logic      mark_o
);
	localparam int MARK_AT = FRAME_CYCLES - MARK_CYCLES;

	logic [iso_ring_pkg::TM_CNT_W-1:0] cnt_r;
	logic                              mark_r;

	// Cycle count since the last start-of-frame; saturates if frames stop.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || sof_i) begin
			cnt_r <= '0;
		end else if (cnt_r != '1) begin
			cnt_r <= cnt_r + 18'h0_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mark_r <= 1'b0;
		end else begin
			mark_r <= !sof_i && cnt_r == iso_ring_pkg::TM_CNT_W'(MARK_AT - 1);
		end
	end

	assign mark_o = mark_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	mark_timing_a: assert property (mark_o |-> cnt_r == iso_ring_pkg::TM_CNT_W'(MARK_AT))
		else $error("time mark not at its lead before the expected frame start");
	mark_cov_c: cover property (mark_o);
endmodule // time_mark_gen

// [core/iso_circular_buffer_dma.sv]
`timescale 1ns/10ps
module iso_circular_buffer_dma #(
	parameter int FRAME_CYCLES = iso_ring_pkg::FRAME_CYCLES,
	parameter int MARK_CYCLES  = iso_ring_pkg::MARK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        sof_i,
	input  wire logic        frame_lsb_i,
	input  wire logic        ubm_wr_valid_i,
	input  wire logic [7:0]  ubm_wr_data_i,
	input  wire logic        ubm_pkt_done_i,
	input  wire logic [6:0]  ubm_pkt_samples_i,
	input  wire logic        ubm_in_token_i,
	input  wire logic        ubm_rd_req_i,
	output logic      [7:0]  ubm_rd_data_o,
	output logic             ubm_rd_valid_o,
	output logic             ubm_in_null_o,
	output logic             ubm_in_end_o,
	input  wire logic        cp_frame_start_i,
	input  wire logic        cp_frame_end_i,
	input  wire logic        cp_tx_req_i,
	output logic      [7:0]  cp_tx_data_o,
	output logic             cp_tx_valid_o,
	input  wire logic        cp_rx_valid_i,
	input  wire logic [7:0]  cp_rx_data_i,
	input  wire logic        cp_rx_sample_i,
	output logic             time_mark_o
);
	typedef enum logic [1:0] {O_WAIT_SOF, O_WAIT_FRAME, O_RUN} out_state_t;
	typedef enum logic [1:0] {U_WAIT_FLAG, U_WAIT_SOF, U_ARMED, U_SEND} ubm_state_t;

	localparam int NR = iso_ring_pkg::NR_BIT;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic                            en_r;
	logic                            dir_in_r;
	logic [1:0]                      bps_r;
	logic [iso_ring_pkg::ADDR_W-1:0] base_r;
	logic [iso_ring_pkg::SIZE_W-1:0] size_r;
	logic                            init;
	logic                            out_en;
	logic                            in_en;

	assign init   = reg_wr_i && reg_addr_i == iso_ring_pkg::CTRL_OFS
		&& reg_wdata_i[iso_ring_pkg::CTRL_EN_BIT] && !en_r;
	assign out_en = en_r && !dir_in_r;
	assign in_en  = en_r && dir_in_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			en_r     <= 1'b0;
			dir_in_r <= 1'b0;
			bps_r    <= 2'h0;
			base_r   <= iso_ring_pkg::BASE_RST;
			size_r   <= iso_ring_pkg::SIZE_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				iso_ring_pkg::CTRL_OFS: begin
					en_r     <= reg_wdata_i[iso_ring_pkg::CTRL_EN_BIT];
					dir_in_r <= reg_wdata_i[iso_ring_pkg::CTRL_DIR_IN_BIT];
					bps_r    <= reg_wdata_i[iso_ring_pkg::CTRL_BPS_LSB +: 2];
				end
				iso_ring_pkg::BUF_BASE_OFS: base_r <= reg_wdata_i[7:0];
				iso_ring_pkg::BUF_SIZE_OFS: size_r <= reg_wdata_i[8:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Ring buffer and pointers
	// ----------------------------------------------------------------
	logic [7:0]                      mem_r [256];
	logic [iso_ring_pkg::ADDR_W-1:0] rd_ptr;
	logic [iso_ring_pkg::ADDR_W-1:0] wr_ptr;
	logic                            wr_adv;
	logic                            rd_adv;
	logic [7:0]                      wr_byte;
	logic                            ptr_diff;
	logic [iso_ring_pkg::SIZE_W-1:0] fill;

	assign wr_adv   = (out_en && ubm_wr_valid_i) || (in_en && cp_rx_valid_i);
	assign wr_byte  = out_en ? ubm_wr_data_i : cp_rx_data_i;
	assign ptr_diff = rd_ptr != wr_ptr;
	assign fill     = iso_ring_pkg::ring_fill(wr_ptr, rd_ptr, size_r);

	ring_cfg_if ring_cfg ();
	assign ring_cfg.base = base_r;
	assign ring_cfg.size = size_r;
	assign ring_cfg.init = init;

	circ_ptr u_rd_ptr (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.cfg     (ring_cfg),
		.adv_i   (rd_adv),
		.ptr_o   (rd_ptr)
	);

	circ_ptr u_wr_ptr (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.cfg     (ring_cfg),
		.adv_i   (wr_adv),
		.ptr_o   (wr_ptr)
	);

	always_ff @(posedge clk_i) begin
		if (wr_adv && !init) begin
			mem_r[wr_ptr] <= wr_byte;
		end
	end

	// ----------------------------------------------------------------
	// OUT direction: ring to codec port
	// ----------------------------------------------------------------
	out_state_t ost_r;
	logic       out_send;

	assign out_send = ost_r == O_RUN && out_en && cp_tx_req_i && ptr_diff;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !out_en) begin
			ost_r <= O_WAIT_SOF;
		end else begin
			unique case (ost_r)
				O_WAIT_SOF: if (sof_i && ptr_diff) begin
					ost_r <= O_WAIT_FRAME;
				end
				O_WAIT_FRAME: if (cp_frame_start_i) begin
					ost_r <= O_RUN;
				end
				O_RUN: if (!ptr_diff) begin
					ost_r <= O_WAIT_SOF;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cp_tx_valid_o <= 1'b0;
			cp_tx_data_o  <= 8'h00;
		end else begin
			cp_tx_valid_o <= out_send;
			if (out_send) begin
				cp_tx_data_o <= mem_r[rd_ptr];
			end
		end
	end

	logic [6:0] out_even_r;
	logic [6:0] out_odd_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			out_even_r <= 7'h00;
			out_odd_r  <= 7'h00;
		end else if (out_en && ubm_pkt_done_i) begin
			if (frame_lsb_i) begin
				out_odd_r <= ubm_pkt_samples_i;
			end else begin
				out_even_r <= ubm_pkt_samples_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// IN direction: codec port to ring, time mark handshake
	// ----------------------------------------------------------------
	logic       mark;
	logic [6:0] samples_r;
	logic       in_frame_r;
	logic       mark_pend_r;
	logic       load;
	logic [6:0] load_cnt;
	logic [7:0] in_first_r;
	logic [7:0] in_second_r;
	logic       both_nr;

	time_mark_gen #(
		.FRAME_CYCLES (FRAME_CYCLES),
		.MARK_CYCLES  (MARK_CYCLES)
	) u_mark (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.sof_i   (sof_i),
		.mark_o  (mark)
	);
	assign time_mark_o = mark;

	assign load     = in_en && mark_pend_r && (!in_frame_r || cp_frame_end_i);
	assign load_cnt = samples_r + 7'(cp_rx_sample_i);
	assign both_nr  = in_first_r[NR] && in_second_r[NR];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !in_en) begin
			samples_r   <= 7'h00;
			in_frame_r  <= 1'b0;
			mark_pend_r <= 1'b0;
		end else begin
			if (load) begin
				samples_r <= 7'(cp_rx_sample_i);
			end else if (cp_rx_sample_i) begin
				samples_r <= samples_r + 7'h01;
			end
			if (cp_frame_start_i) begin
				in_frame_r <= 1'b1;
			end else if (cp_frame_end_i) begin
				in_frame_r <= 1'b0;
			end
			mark_pend_r <= mark || (mark_pend_r && !load);
		end
	end

	// ----------------------------------------------------------------
	// IN side of the buffer manager
	// ----------------------------------------------------------------
	ubm_state_t ust_r;
	logic       u_first_r;
	logic [8:0] byte_cnt_r;
	logic [8:0] byte_goal_r;
	logic       in_send;
	logic       in_end;

	assign in_send = ust_r == U_SEND && ubm_rd_req_i && byte_cnt_r != byte_goal_r;
	assign in_end  = ust_r == U_SEND && byte_cnt_r == byte_goal_r;
	assign rd_adv  = out_send || in_send;

	// A load from the codec side wins over the buffer manager on the same register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || init) begin
			in_first_r  <= iso_ring_pkg::INCNT_RST;
			in_second_r <= iso_ring_pkg::INCNT_RST;
		end else begin
			if (in_end && u_first_r) begin
				in_first_r[NR] <= 1'b1;
			end
			if (in_end && !u_first_r) begin
				in_second_r[NR] <= 1'b1;
			end
			if (load && frame_lsb_i) begin
				in_first_r <= {1'b0, load_cnt};
			end
			if (load && !frame_lsb_i) begin
				in_second_r <= {1'b0, load_cnt};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !in_en) begin
			ust_r       <= U_WAIT_FLAG;
			u_first_r   <= 1'b1;
			byte_cnt_r  <= 9'h000;
			byte_goal_r <= 9'h000;
		end else begin
			unique case (ust_r)
				U_WAIT_FLAG: if (!both_nr) begin
					ust_r <= U_WAIT_SOF;
				end
				U_WAIT_SOF: if (sof_i) begin
					ust_r     <= U_ARMED;
					u_first_r <= !in_first_r[NR];
				end
				U_ARMED: if (ubm_in_token_i) begin
					ust_r       <= U_SEND;
					byte_cnt_r  <= 9'h000;
					byte_goal_r <= u_first_r
						? 9'(in_first_r[6:0]) * (9'(bps_r) + 9'h001)
						: 9'(in_second_r[6:0]) * (9'(bps_r) + 9'h001);
				end
				U_SEND: begin
					if (in_end) begin
						ust_r <= U_WAIT_FLAG;
					end else if (in_send) begin
						byte_cnt_r <= byte_cnt_r + 9'h001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ubm_rd_valid_o <= 1'b0;
			ubm_rd_data_o  <= 8'h00;
			ubm_in_null_o  <= 1'b0;
			ubm_in_end_o   <= 1'b0;
		end else begin
			ubm_rd_valid_o <= in_send;
			if (in_send) begin
				ubm_rd_data_o <= mem_r[rd_ptr];
			end
			ubm_in_null_o <= in_en && ubm_in_token_i && both_nr && ust_r != U_SEND;
			ubm_in_end_o  <= in_end;
		end
	end

	// ----------------------------------------------------------------
	// Level count and register reads
	// ----------------------------------------------------------------
	logic [iso_ring_pkg::SIZE_W-1:0] level_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			level_r <= 9'h000;
		end else if (sof_i) begin
			level_r <= fill;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !reg_rd_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			unique case (reg_addr_i)
				iso_ring_pkg::CTRL_OFS:      reg_rdata_o <= {12'h000, bps_r, dir_in_r, en_r};
				iso_ring_pkg::BUF_BASE_OFS:  reg_rdata_o <= {8'h00, base_r};
				iso_ring_pkg::BUF_SIZE_OFS:  reg_rdata_o <= {7'h00, size_r};
				iso_ring_pkg::RD_PTR_OFS:    reg_rdata_o <= {8'h00, rd_ptr};
				iso_ring_pkg::WR_PTR_OFS:    reg_rdata_o <= {8'h00, wr_ptr};
				iso_ring_pkg::OUT_EVEN_OFS:  reg_rdata_o <= {9'h000, out_even_r};
				iso_ring_pkg::OUT_ODD_OFS:   reg_rdata_o <= {9'h000, out_odd_r};
				iso_ring_pkg::IN_FIRST_OFS:  reg_rdata_o <= {8'h00, in_first_r};
				iso_ring_pkg::IN_SECOND_OFS: reg_rdata_o <= {8'h00, in_second_r};
				iso_ring_pkg::LEVEL_OFS:     reg_rdata_o <= {7'h00, level_r};
				default:                     reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	ptr_read_a: assert property (reg_rd_i && reg_addr_i == iso_ring_pkg::RD_PTR_OFS
		|=> reg_rdata_o == {8'h00, $past(rd_ptr)})
		else $error("read pointer not visible on register read");
	out_store_a: assert property (out_en && ubm_wr_valid_i && !init
		|=> mem_r[$past(wr_ptr)] == $past(ubm_wr_data_i))
		else $error("OUT byte not stored at write pointer");
	out_hold_sof_a: assert property (ost_r == O_WAIT_SOF && !sof_i
		|=> ost_r != O_WAIT_FRAME)
		else $error("OUT transfer started without start-of-frame");
	out_send_run_a: assert property (cp_tx_valid_o |-> $past(ost_r) == O_RUN)
		else $error("codec byte sent outside running state");
	out_pause_a: assert property (out_en && ost_r == O_RUN && !ptr_diff
		|=> ost_r == O_WAIT_SOF)
		else $error("OUT transfer did not pause on empty ring");
	out_count_sel_a: assert property (out_en && ubm_pkt_done_i && frame_lsb_i
		|=> out_odd_r == $past(ubm_pkt_samples_i))
		else $error("OUT sample count not in odd register");
	in_init_flags_a: assert property (init |=> in_first_r == 8'h80 && in_second_r == 8'h80)
		else $error("IN count registers not initialised");
	in_load_a: assert property (load && frame_lsb_i && !init
		|=> in_first_r == {1'b0, $past(load_cnt)} ##1 samples_r <= 7'h02)
		else $error("IN count not loaded at time mark");
	in_wait_frame_a: assert property (in_frame_r && !cp_frame_end_i |-> !load)
		else $error("IN count loaded during a codec frame");
	in_sof_gate_a: assert property (ust_r == U_WAIT_SOF && !sof_i |=> ust_r != U_ARMED)
		else $error("IN data phase armed without start-of-frame");
	in_null_a: assert property (in_en && ubm_in_token_i && both_nr && ust_r != U_SEND
		|=> ubm_in_null_o)
		else $error("no zero-length answer with both flags not ready");
	level_a: assert property (sof_i |=> level_r == $past(fill))
		else $error("level count not latched at start-of-frame");

	out_pause_c: cover property (ost_r == O_RUN ##1 ost_r == O_WAIT_SOF);
	in_load_c: cover property (load);
	in_end_c: cover property (ubm_in_end_o);
	in_null_c: cover property (ubm_in_null_o);
endmodule // iso_circular_buffer_dma

// [test/codec_port_model.sv]
`timescale 1ns/10ps
module codec_port_model (
	input  wire logic       clk_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            start_o,
	output logic            end_o,
	output logic            tx_req_o,
	output logic            rx_valid_o,
	output logic            rx_sample_o,
	output logic      [7:0] rx_data_o
);
	logic [7:0] got[$];

	initial begin
		{start_o, end_o, tx_req_o, rx_valid_o, rx_sample_o} = '0;
		rx_data_o = 8'h5a;
	end

	always @(posedge clk_i) if (tx_valid_i) got.push_back(tx_data_i);

	// One codec frame: n back-to-back byte slots, pulled out or pushed in.
	// An input sample is complete after every per bytes.
	task frame(input int n, input logic rx, input int per = 1);
		@(posedge clk_i) start_o <= 1'b1;
		@(posedge clk_i) start_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			tx_req_o <= !rx;
			rx_valid_o <= rx;
			rx_sample_o <= rx && (i % per == per - 1);
			rx_data_o <= 8'ha0 + 8'(i);
			@(posedge clk_i);
		end
		{tx_req_o, rx_valid_o, rx_sample_o} <= '0;
		// The data line is inverted, so it no longer shows the last byte.
		rx_data_o <= ~rx_data_o;
		end_o <= 1'b1;
		@(posedge clk_i) end_o <= 1'b0;
	endtask
endmodule // codec_port_model

// [test/iso_circular_buffer_dma_bench.sv]
`timescale 1ns/10ps
module iso_circular_buffer_dma_bench;
	localparam int FRAME = 400;
	localparam int MARK  = 60;
	logic        clk, rst_n, wr, rd, sof, lsb, wv, done, tok, rreq, rv, inull, iend, tmark;
	logic        fs, fe, treq, tv, rxv, rxs;
	logic [3:0]  addr;
	logic [6:0]  smp;
	logic [7:0]  wd, rdd, txd, rxd;
	logic [15:0] wdata, rdata;
	int          n_mismatch = 0;
	int          compares = 0;
	int          since;

	iso_circular_buffer_dma #(.FRAME_CYCLES(FRAME), .MARK_CYCLES(MARK))
		iso_circular_buffer_dma_inst (
		.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sof_i(sof), .frame_lsb_i(lsb),
		.ubm_wr_valid_i(wv), .ubm_wr_data_i(wd), .ubm_pkt_done_i(done),
		.ubm_pkt_samples_i(smp), .ubm_in_token_i(tok), .ubm_rd_req_i(rreq),
		.ubm_rd_data_o(rdd), .ubm_rd_valid_o(rv), .ubm_in_null_o(inull), .ubm_in_end_o(iend),
		.cp_frame_start_i(fs), .cp_frame_end_i(fe), .cp_tx_req_i(treq), .cp_tx_data_o(txd),
		.cp_tx_valid_o(tv), .cp_rx_valid_i(rxv), .cp_rx_data_i(rxd), .cp_rx_sample_i(rxs),
		.time_mark_o(tmark));
	codec_port_model codec_port_model_inst (.clk_i(clk), .tx_valid_i(tv), .tx_data_i(txd),
		.start_o(fs), .end_o(fe), .tx_req_o(treq), .rx_valid_o(rxv), .rx_sample_o(rxs),
		.rx_data_o(rxd));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) since <= (sof || !rst_n) ? 0 : since + 1;
	always @(posedge clk) if (tmark) ck("mark", 16'(since), 16'(FRAME - MARK));

	// ----------------------------------------------------------------
	// Bus and check helpers
	// ----------------------------------------------------------------
	task automatic ck(input string nm, input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rc(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 ck($sformatf("reg %0d", a), rdata, e);
	endtask
	task pulse(input int w);
		@(posedge clk);
		case (w)
			0: sof <= 1'b1;
			1: wv <= 1'b1;
			2: done <= 1'b1;
			3: tok <= 1'b1;
			default: rreq <= 1'b1;
		endcase
		@(posedge clk);
		{sof, wv, done, tok, rreq} <= '0;
		#1;
	endtask
	task txq(input int n, input logic [7:0] b);
		repeat (2) @(posedge clk);
		ck("tx count", 16'(codec_port_model_inst.got.size()), 16'(n));
		for (int i = 0; i < n; i++) ck("tx byte", 16'(codec_port_model_inst.got[i]), 16'(b + 8'(i)));
	endtask
	task cfg(input logic [15:0] base, input logic [15:0] size, input logic [15:0] ctrl);
		rw(iso_ring_pkg::CTRL_OFS, 16'h0000);
		rw(iso_ring_pkg::BUF_BASE_OFS, base);
		rw(iso_ring_pkg::BUF_SIZE_OFS, size);
		rw(iso_ring_pkg::CTRL_OFS, ctrl);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_out;
		cfg(16'h0010, 16'h0004, 16'h0001);
		rw(iso_ring_pkg::RD_PTR_OFS, 16'h0055);
		rc(iso_ring_pkg::RD_PTR_OFS, 16'h0010);
		for (int i = 0; i < 3; i++) begin
			wd <= 8'hb0 + 8'(i);
			pulse(1);
		end
		rc(iso_ring_pkg::WR_PTR_OFS, 16'h0013);
		lsb <= 1'b1;
		smp <= 7'd3;
		pulse(2);
		lsb <= 1'b0;
		smp <= 7'd2;
		pulse(2);
		rc(iso_ring_pkg::OUT_ODD_OFS, 16'h0003);
		rc(iso_ring_pkg::OUT_EVEN_OFS, 16'h0002);
		codec_port_model_inst.frame(2, 1'b0);
		txq(0, 8'hb0);
		pulse(0);
		codec_port_model_inst.frame(5, 1'b0);
		txq(3, 8'hb0);
		rc(iso_ring_pkg::RD_PTR_OFS, 16'h0013);
		for (int i = 3; i < 5; i++) begin
			wd <= 8'hb0 + 8'(i);
			pulse(1);
		end
		rc(iso_ring_pkg::WR_PTR_OFS, 16'h0011);
		codec_port_model_inst.frame(3, 1'b0);
		txq(3, 8'hb0);
		pulse(0);
		rc(iso_ring_pkg::LEVEL_OFS, 16'h0002);
		codec_port_model_inst.frame(3, 1'b0);
		txq(5, 8'hb0);
		wd <= 8'hb5;
		pulse(1);
		rw(iso_ring_pkg::CTRL_OFS, 16'h0000);
		pulse(0);
		codec_port_model_inst.frame(2, 1'b0);
		txq(5, 8'hb0);
		$display("test out done");
	endtask

	task in_frame(input logic l, input int n, input int per, input logic [3:0] r);
		lsb <= l;
		pulse(0);
		codec_port_model_inst.frame(n, 1'b1, per);
		for (int i = 0; i < 500 && tmark !== 1'b1; i++) @(posedge clk);
		ck("mark seen", 16'(tmark), 16'h0001);
		rc(r, 16'(n / per));
		pulse(3);
		ck("early token", 16'(inull), 16'h0000);
		pulse(4);
		ck("early read", 16'(rv), 16'h0000);
		pulse(0);
		pulse(3);
		for (int i = 0; i < n; i++) begin
			pulse(4);
			ck("in byte", {7'h00, rv, rdd}, {8'h01, 8'ha0 + 8'(i)});
		end
		for (int i = 0; i < 4 && iend !== 1'b1; i++) @(posedge clk) #1;
		ck("in end", 16'(iend), 16'h0001);
		rc(r, 16'h0080 | 16'(n / per));
	endtask

	task t_in;
		cfg(16'h0020, 16'h0010, 16'h0003);
		rc(iso_ring_pkg::IN_SECOND_OFS, 16'h0080);
		rc(iso_ring_pkg::WR_PTR_OFS, 16'h0020);
		pulse(3);
		ck("null packet", 16'(inull), 16'h0001);
		in_frame(1'b1, 3, 1, iso_ring_pkg::IN_FIRST_OFS);
		rc(iso_ring_pkg::RD_PTR_OFS, 16'h0023);
		rw(iso_ring_pkg::CTRL_OFS, 16'h0007);
		in_frame(1'b0, 4, 2, iso_ring_pkg::IN_SECOND_OFS);
		$display("test in done");
	endtask

	task conclude;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		{rst_n, wr, rd, sof, lsb, wv, done, tok, rreq} = '0;
		{addr, wdata, wd, smp} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rc(iso_ring_pkg::BUF_SIZE_OFS, 16'h0100);
		rc(iso_ring_pkg::IN_FIRST_OFS, 16'h0080);
		t_out;
		t_in;
		conclude;
	end

	initial begin
		#100000;
		n_mismatch++;
		conclude;
	end
endmodule // iso_circular_buffer_dma_bench
